// ==== ptc_capture.v ====
`timescale 1ns/1ps
`include "ptc_consts.vh"
module ptc_capture
#(
  parameter NPINS     = 4,
  parameter SELW      = 2,
  parameter DEPTH     = 16,
  parameter AW        = 4,
  parameter DEF_PIN   = 0
)
(
  input  wire             clk_in,
  input  wire             rst_in,
  input  wire [NPINS-1:0] pins_in,
  input  wire             start_in,
  input  wire             abort_in,
  input  wire             use_pin_in,
  input  wire [SELW-1:0]  pin_sel_in,
  input  wire [7:0]       edge_flags_in,
  input  wire [AW:0]      count_in,
  input  wire [15:0]      timeout_in,
  input  wire [7:0]       tick_prescale_select_in,
  input  wire [AW-1:0]    rd_addr_in,
  output reg  [15:0]      rd_data_out,
  output reg  [AW:0]      stored_out,
  output wire             busy_out,
  output reg              done_out,
  output reg              timed_out_out,
  output reg              bad_flags_out
);
  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_FILL = 2'b01;
  localparam ST_ARM  = 2'b10;
  localparam ST_RUN  = 2'b11;

  reg  [15:0]      buf_mem [0:DEPTH-1];
  reg  [1:0]       state;
  reg  [AW:0]      fill_idx;
  reg  [AW:0]      cnt;
  reg  [SELW-1:0]  sel;
  reg              want_rise;
  reg  [15:0]      tmo_n;
  reg  [7:0]       pre_cnt;
  reg  [15:0]      timer;
  reg  [15:0]      last_ts;
  reg              ovf;
  reg  [16:0]      tmo_lo;
  reg  [15:0]      tmo_hi;
  reg  [NPINS-1:0] s1;
  reg  [NPINS-1:0] s2;
  reg  [NPINS-1:0] s3;
  reg              lvl;
  wire             tick;
  wire             cur;
  wire             edge_seen;
  wire [15:0]      diff;
  wire [15:0]      width;

  assign busy_out = (state != ST_IDLE);
  // ---------------------------------------------------------------
  // Input synchroniser, pin select and edge detect
  // ---------------------------------------------------------------
  always @(posedge clk_in)
  begin
    s1 <= pins_in;
    s2 <= s1;
    s3 <= s2;
  end

  assign cur = s2[sel];
  // A change counts only once stages two and three agree
  assign edge_seen = (cur == s3[sel]) && (s3[sel] != lvl);

  // ---------------------------------------------------------------
  // Tick generation and free-running timer
  // ---------------------------------------------------------------
  assign tick = (pre_cnt >= tick_prescale_select_in);

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pre_cnt <= 8'h00;
      timer   <= 16'h0000;
    end
    else if (tick)
    begin
      pre_cnt <= 8'h00;
      timer   <= timer + 16'h0001;
    end
    else
    begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  // Widths are stamp differences, so the timer may wrap freely
  // and the fixed edge-detect delay cancels out of every width
  assign diff  = timer - last_ts;
  assign width = ovf ? `PTC_SAT : diff;

  // ---------------------------------------------------------------
  // Control
  // ---------------------------------------------------------------
  always @(posedge clk_in)
  begin
    rd_data_out <= buf_mem[rd_addr_in];
    if (rst_in)
    begin
      state         <= ST_IDLE;
      fill_idx      <= {(AW+1){1'b0}};
      cnt           <= {(AW+1){1'b0}};
      sel           <= DEF_PIN[SELW-1:0];
      want_rise     <= 1'b0;
      tmo_n         <= 16'h0000;
      last_ts       <= 16'h0000;
      ovf           <= 1'b0;
      tmo_lo        <= 17'h00000;
      tmo_hi        <= 16'h0000;
      lvl           <= 1'b0;
      stored_out    <= {(AW+1){1'b0}};
      done_out      <= 1'b0;
      timed_out_out <= 1'b0;
      bad_flags_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          lvl <= s3[sel];
          if (start_in)
          begin
            bad_flags_out <= (edge_flags_in != `PTC_EDGE_FALL) &&
                             (edge_flags_in != `PTC_EDGE_RISE);
            sel       <= use_pin_in ? pin_sel_in : DEF_PIN[SELW-1:0];
            want_rise <= (edge_flags_in == `PTC_EDGE_RISE);
            cnt       <= (count_in > DEPTH[AW:0]) ? DEPTH[AW:0] : count_in;
            tmo_n     <= timeout_in;
            fill_idx  <= {(AW+1){1'b0}};
            stored_out    <= {(AW+1){1'b0}};
            timed_out_out <= 1'b0;
            state     <= ST_FILL;
          end
        end
        ST_FILL:
        begin
          buf_mem[fill_idx[AW-1:0]] <= `PTC_MARK;
          fill_idx <= fill_idx + {{AW{1'b0}}, 1'b1};
          lvl      <= s3[sel];
          tmo_lo   <= 17'h00000;
          tmo_hi   <= 16'h0000;
          if (fill_idx == DEPTH[AW:0] - {{AW{1'b0}}, 1'b1})
            state <= (cnt == {(AW+1){1'b0}}) ? ST_IDLE : ST_ARM;
          if (abort_in || (fill_idx == DEPTH[AW:0] - {{AW{1'b0}}, 1'b1}
              && cnt == {(AW+1){1'b0}}))
          begin
            state    <= ST_IDLE;
            done_out <= 1'b1;
          end
        end
        default:
        begin
          if (tick && tmo_n != 16'h0000)
          begin
            if (tmo_lo == `PTC_TMO_TICKS - 17'h00001)
            begin
              tmo_lo <= 17'h00000;
              tmo_hi <= tmo_hi + 16'h0001;
            end
            else
              tmo_lo <= tmo_lo + 17'h00001;
          end
          // Flag a segment that outgrows sixteen bits before it wraps
          if (state == ST_RUN && tick && diff == `PTC_SAT)
            ovf <= 1'b1;
          if (edge_seen)
          begin
            lvl <= s3[sel];
            if (state == ST_ARM)
            begin
              if (s3[sel] == want_rise)
              begin
                last_ts <= timer;
                ovf     <= 1'b0;
                state   <= ST_RUN;
              end
            end
            else
            begin
              buf_mem[stored_out[AW-1:0]] <= width;
              stored_out <= stored_out + {{AW{1'b0}}, 1'b1};
              last_ts    <= timer;
              ovf        <= 1'b0;
              if (stored_out + {{AW{1'b0}}, 1'b1} == cnt)
              begin
                state    <= ST_IDLE;
                done_out <= 1'b1;
              end
            end
          end
          if (tmo_n != 16'h0000 && tmo_hi == tmo_n)
          begin
            state         <= ST_IDLE;
            done_out      <= 1'b1;
            timed_out_out <= 1'b1;
          end
          else if (abort_in)
          begin
            state    <= ST_IDLE;
            done_out <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule

// ==== ptc_capture_assertions.sv ====
`timescale 1ns/1ps
module ptc_capture_chk
#(
  parameter AW    = 4,
  parameter DEPTH = 16
)
(
  input wire        clk_in,
  input wire        rst_in,
  input wire        start_in,
  input wire        abort_in,
  input wire [7:0]  edge_flags_in,
  input wire [AW:0] stored_out,
  input wire        busy_out,
  input wire        done_out,
  input wire        timed_out_out,
  input wire        bad_flags_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire go = start_in && !busy_out;
  a_start_busy: assert property (go |=> busy_out) else $error("no busy");
  a_done_pulse:
    assert property (done_out |=> !done_out) else $error("long");
  a_end_done:
    assert property ($fell(busy_out) |-> done_out) else $error("no done");
  a_abort_end:
    assert property (busy_out && abort_in |-> ##[1:2] done_out)
      else $error("abort");
  a_idle_abort:
    assert property (!busy_out && abort_in && !start_in |=> !busy_out)
      else $error("idle abort");
  a_stored_cap: assert property (stored_out <= DEPTH) else $error("cap");
  a_stored_hold:
    assert property (!busy_out && !start_in |=> $stable(stored_out))
      else $error("stored moved");
  a_tmo_done:
    assert property ($rose(timed_out_out) |-> done_out) else $error("tmo");
  a_tmo_clear:
    assert property (go |=> !timed_out_out) else $error("tmo");
  a_flags_chk:
    assert property (go |=> bad_flags_out == ($past(edge_flags_in) > 8'h01))
      else $error("flags");
endmodule
bind ptc_capture ptc_capture_chk #(.AW(AW), .DEPTH(DEPTH)) u_chk (.clk_in,
  .rst_in, .start_in, .abort_in, .edge_flags_in, .stored_out, .busy_out,
  .done_out, .timed_out_out, .bad_flags_out);

// ==== ptc_capture_test.sv ====
`timescale 1ns/1ps
module ptc_capture_test;
  reg         clk_in = 1'b0, rst_in = 1'b1, start_in = 1'b0, abort_in = 1'b0;
  reg         use_pin_in = 1'b0, run = 1'b0, lvl = 1'b0;
  reg  [1:0]  pin_sel_in = 2'h0, pin = 2'h0;
  reg  [7:0]  edge_flags_in = 8'h00, tick_prescale_select_in = 8'h00;
  reg  [4:0]  count_in = 5'h00;
  reg  [15:0] timeout_in = 16'h0000;
  reg  [3:0]  rd_addr_in = 4'h0;
  reg  [16:0] seg = 17'h0012C;
  wire        src, busy_out, done_out, timed_out_out, bad_flags_out;
  wire [15:0] rd_data_out;
  wire [4:0]  stored_out;
  wire [3:0]  pins_in = src ? (4'h1 << pin) : 4'h0;
  integer     n_fail = 0, tests_run = 0, cyc = 0, k, i;
  ptc_capture u_ptc_capture (.clk_in, .rst_in, .pins_in, .start_in, .abort_in,
    .use_pin_in, .pin_sel_in, .edge_flags_in, .count_in, .timeout_in,
    .tick_prescale_select_in, .rd_addr_in, .rd_data_out, .stored_out,
    .busy_out, .done_out, .timed_out_out, .bad_flags_out);
  ptc_src u_ptc_src (.clk_in, .run_in(run), .lvl_in(lvl), .seg_in(seg),
    .pin_out(src));
  initial forever #25 clk_in = ~clk_in;
  task end_sim;
    begin
      if (n_fail == 0 && tests_run > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 90000)
    begin
      n_fail = n_fail + 1;
      end_sim;
    end
  end
  task chk(input [16:0] got, input [16:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rd(input [3:0] a, input [15:0] e);
    begin
      rd_addr_in = a;
      @(negedge clk_in);
      chk(rd_data_out, e);
    end
  endtask
  // Start, let the fill finish, then run the source or abort
  task cap(input [7:0] f, input [4:0] c, input [15:0] t, input ab);
    begin
      edge_flags_in = f;
      count_in = c;
      timeout_in = t;
      start_in = 1'b1;
      @(negedge clk_in);
      start_in = 1'b0;
      chk(busy_out, 17'h00001);
      k = 1;
      while (!done_out)
      begin
        if (k == 31)
        begin
          if (ab) abort_in = 1'b1; else run = 1'b1;
        end
        @(negedge clk_in);
        abort_in = 1'b0;
        k = k + 1;
      end
      run = 1'b0;
      chk(busy_out, 17'h00000);
    end
  endtask
  initial
  begin
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    cap(8'h01, 5'h04, 16'h0000, 1'b0);
    for (i = 0; i < 16; i = i + 1) rd(i, i < 4 ? 16'h012C : 16'hFFFE);
    chk(stored_out, 17'h00004);
    cap(8'h00, 5'h00, 16'h0000, 1'b0);
    chk(k, 17'h00011);
    chk(stored_out, 17'h00000);
    for (i = 0; i < 4; i = i + 1) rd(i, 16'hFFFE);
    use_pin_in = 1'b1;
    pin_sel_in = 2'h2;
    pin = 2'h2;
    lvl = 1'b1;
    tick_prescale_select_in = 8'h01;
    cap(8'h00, 5'h03, 16'h0000, 1'b0);
    for (i = 0; i < 4; i = i + 1) rd(i, i < 3 ? 16'h0096 : 16'hFFFE);
    cap(8'h05, 5'h03, 16'h0000, 1'b1);
    chk(bad_flags_out, 17'h00001);
    chk(stored_out, 17'h00000);
    @(negedge clk_in);
    abort_in = 1'b1;
    @(negedge clk_in);
    abort_in = 1'b0;
    chk(busy_out, 17'h00000);
    chk(done_out, 17'h00000);
    tick_prescale_select_in = 8'h00;
    seg = 17'h1FFFF;
    cap(8'h00, 5'h02, 16'h0001, 1'b0);
    chk(timed_out_out, 17'h00001);
    chk(k >= 65550 && k <= 65600, 17'h00001);
    cap(8'h00, 5'h01, 16'h0000, 1'b1);
    chk(timed_out_out, 17'h00000);
    end_sim;
  end
endmodule

// ==== ptc_consts.vh ====
// Behaviour
// - Start edge select: 0 arms on falling, 1 on rising, others reserved.
// - After the start edge, each alternating segment fills one slot.
// - Overlong segment stores 65535; the following slot still holds a valid width.
// - Before capture every buffer slot is filled with marker 65534.
// - Widths count ticks, one per clock by default, lengthened by prescale.
// - Nonzero timeout N ends capture after N*65536 ticks; zero disables it.
// - Capture runs until count stored, timeout, or abort, then reports done.
// - Capture pin selectable; default pin used unless one is named.
`ifndef PTC_CONSTS_VH
`define PTC_CONSTS_VH
`define PTC_W 16
`define PTC_SAT 16'hFFFF
`define PTC_MARK 16'hFFFE
`define PTC_EDGE_FALL 8'h00
`define PTC_EDGE_RISE 8'h01
`define PTC_TMO_TICKS 17'h10000
`define PTC_MIN_SEG_CYC 300
`endif

// ==== ptc_src.sv ====
`timescale 1ns/1ps
module ptc_src
(
  input  wire        clk_in,
  input  wire        run_in,
  input  wire        lvl_in,
  input  wire [16:0] seg_in,
  output reg         pin_out
);
  reg [16:0] cnt = 17'h00001;
  initial pin_out = 1'b0;
  // Idle at the given level, else toggle every seg_in clocks
  always @(posedge clk_in)
    if (!run_in)
    begin
      pin_out <= lvl_in;
      cnt     <= 17'h00001;
    end
    else if (cnt >= seg_in)
    begin
      pin_out <= ~pin_out;
      cnt     <= 17'h00001;
    end
    else
      cnt <= cnt + 17'h00001;
endmodule
